// ### core/evt_cap_pkg.sv
package evt_cap_pkg;
  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int unsigned NUM_CH     = 64;
  localparam int unsigned CH_W       = 6;
  localparam int unsigned ADDR_W     = 9;
  localparam int unsigned DATA_W     = 32;

  // ------------------------------------------------------------
  // address map: byte addresses, a low and a high word per register
  // ------------------------------------------------------------
  localparam logic [8:0] SHADOW_BASE = 9'h100;
  localparam logic [7:0] OFF_PEND    = 8'h00;
  localparam logic [7:0] OFF_CLR     = 8'h08;
  localparam logic [7:0] OFF_EN      = 8'h10;
  localparam logic [7:0] OFF_MISS    = 8'h18;
  localparam logic [7:0] OFF_MISSCLR = 8'h20;
  localparam logic [7:0] OFF_RAE     = 8'h28;
  localparam logic [7:0] OFF_HIGH    = 8'h04;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [63:0] RST_PEND   = 64'h0000_0000_0000_0000;
  localparam logic [63:0] RST_EN     = 64'h0000_0000_0000_0000;
  localparam logic [63:0] RST_MISS   = 64'h0000_0000_0000_0000;
  localparam logic [63:0] RST_RAE    = 64'h0000_0000_0000_0000;
  localparam logic [31:0] RST_RDATA  = 32'h0000_0000;
endpackage

// ### core/evt_chan_cell.sv
`timescale 1ns/1ns
`default_nettype none
module evt_chan_cell
  import evt_cap_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  input  wire logic set_i,
  input  wire logic clr_hw_i,
  input  wire logic clr_sw_i,
  input  wire logic en_i,
  input  wire logic miss_clr_i,
  output logic      pend_o,
  output logic      miss_o
);
  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic pend_reg;
  logic miss_reg;
  wire  clr_any   = clr_hw_i | clr_sw_i;
  // set beats any clear so an event never vanishes in a race
  wire  pend_next = set_i ? 1'b1 : (clr_any ? 1'b0 : pend_reg);
  // a second event on a pending bit that is enabled or being cleared is lost: record it
  wire  miss_hit  = set_i & pend_reg & (en_i | clr_any);
  wire  miss_next = miss_hit ? 1'b1 : (miss_clr_i ? 1'b0 : miss_reg);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_reg <= 1'b0;
      miss_reg <= 1'b0;
    end else if (ce_i) begin
      pend_reg <= pend_next;
      miss_reg <= miss_next;
    end
  end

  assign pend_o = pend_reg;
  assign miss_o = miss_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  set_wins_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && set_i |=> pend_reg) else $error("set lost");
  sw_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && clr_sw_i && !set_i |=> !pend_reg) else $error("sw clear ignored");
  hw_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && clr_hw_i && !set_i |=> !pend_reg) else $error("service clear ignored");
  miss_en_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && set_i && pend_reg && en_i |=> miss_reg) else $error("miss not flagged");
  miss_race_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && set_i && pend_reg && clr_any |=> miss_reg && pend_reg)
    else $error("race miss not flagged");
  race_fresh_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && set_i && !pend_reg && clr_any && !miss_clr_i |=> pend_reg && $stable(miss_reg))
    else $error("fresh race wrong");
  idle_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && !set_i && !clr_any |=> $stable(pend_reg)) else $error("pending changed idle");
  freeze_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ce_i |=> $stable(pend_reg) && $stable(miss_reg)) else $error("state moved while frozen");

  race_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && set_i && clr_any);
  miss_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && miss_hit);
endmodule
`default_nettype wire

// ### core/evt_capture.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Overview of operation
// - 64 channels, low/high 32-bit register pairs
// - every event seen while ce_i high latches its channel pending bit
// - events latch even on disabled channels
// - offer pending only where channel enabled
// - servicing a channel clears its pending bit
// - repeat event on enabled pending sets miss
// - writing one to clear register clears pending
// - set wins over simultaneous clear
// - race on already-pending bit sets miss
// - race on idle bit leaves it pending
// - registers reachable through global range
// - shadow range gated by region access enables
// - zeros written to clear register ignored
// ------------------------------------------------------------
module evt_capture
  import evt_cap_pkg::*;
(
  input  wire logic [NUM_CH-1:0] evt_i,
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              ce_i,
  input  wire logic              service_i,
  input  wire logic [CH_W-1:0]   service_ch_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  output logic      [NUM_CH-1:0] offer_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [NUM_CH-1:0] evt_prev_reg;
  logic [NUM_CH-1:0] en_reg;
  logic [NUM_CH-1:0] rae_reg;
  logic [NUM_CH-1:0] offer_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [NUM_CH-1:0] pend;
  logic [NUM_CH-1:0] miss;

  // ------------------------------------------------------------
  // event pulses
  // ------------------------------------------------------------
  // a held level counts once; a new event needs the line to drop first
  wire [NUM_CH-1:0] evt_pulse = evt_i & ~evt_prev_reg;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire              is_shadow = (reg_addr_i[8] == SHADOW_BASE[8]);
  wire [7:0]        off       = reg_addr_i[7:0];
  wire [7:0]        pair_off  = {off[7:3], 3'b000};
  wire              hi_half   = (off[2] == OFF_HIGH[2]);
  wire              word_ok   = (off[1:0] == 2'b00);
  wire [NUM_CH-1:0] lane      = hi_half ? {32'hFFFF_FFFF, 32'h0000_0000}
                                        : {32'h0000_0000, 32'hFFFF_FFFF};
  wire [NUM_CH-1:0] wr_word   = hi_half ? {reg_wdata_i, 32'h0000_0000}
                                        : {32'h0000_0000, reg_wdata_i};
  // shadow side sees only the channels its region owns
  wire [NUM_CH-1:0] acc       = is_shadow ? rae_reg : 64'hFFFF_FFFF_FFFF_FFFF;
  wire [NUM_CH-1:0] wbits     = wr_word & acc;
  wire [NUM_CH-1:0] wlane     = lane & acc;

  wire wr_ok      = reg_wr_i & word_ok;
  wire wr_clr     = wr_ok & (pair_off == OFF_CLR);
  wire wr_en      = wr_ok & (pair_off == OFF_EN);
  wire wr_missclr = wr_ok & (pair_off == OFF_MISSCLR);
  // access enables are written from the global range only; the shadow range can still read them
  wire wr_rae     = wr_ok & (pair_off == OFF_RAE) & ~is_shadow;

  // only ones act; zeros leave pending bits alone
  wire [NUM_CH-1:0] clr_sw    = wr_clr ? wbits : 64'h0000_0000_0000_0000;
  wire [NUM_CH-1:0] miss_clr  = wr_missclr ? wbits : 64'h0000_0000_0000_0000;
  wire [NUM_CH-1:0] clr_hw    = service_i ? (64'h0000_0000_0000_0001 << service_ch_i)
                                          : 64'h0000_0000_0000_0000;
  wire [NUM_CH-1:0] en_next   = wr_en ? ((en_reg & ~wlane) | wbits) : en_reg;
  wire [NUM_CH-1:0] rae_next  = wr_rae ? ((rae_reg & ~lane) | wr_word) : rae_reg;

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  wire [NUM_CH-1:0] rd_sel =
    !word_ok                ? 64'h0000_0000_0000_0000 :
    (pair_off == OFF_PEND)  ? pend :
    (pair_off == OFF_EN)    ? en_reg :
    (pair_off == OFF_MISS)  ? miss :
    (pair_off == OFF_RAE)   ? rae_reg :
                              64'h0000_0000_0000_0000;
  wire [NUM_CH-1:0] rd_acc  = rd_sel & acc;
  wire [DATA_W-1:0] rd_word = hi_half ? rd_acc[63:32] : rd_acc[31:0];
  wire [DATA_W-1:0] acc_half = hi_half ? acc[63:32] : acc[31:0];
  wire [DATA_W-1:0] rdata_next = reg_rd_i ? rd_word : rdata_reg;

  // ------------------------------------------------------------
  // channel cells
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      evt_chan_cell u_cell (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .ce_i       (ce_i),
        .set_i      (evt_pulse[g]),
        .clr_hw_i   (clr_hw[g]),
        .clr_sw_i   (clr_sw[g]),
        .en_i       (en_reg[g]),
        .miss_clr_i (miss_clr[g]),
        .pend_o     (pend[g]),
        .miss_o     (miss[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      evt_prev_reg <= RST_PEND;
      en_reg       <= RST_EN;
      rae_reg      <= RST_RAE;
      offer_reg    <= RST_PEND;
      rdata_reg    <= RST_RDATA;
    end else if (ce_i) begin
      evt_prev_reg <= evt_i;
      en_reg       <= en_next;
      rae_reg      <= rae_next;
      offer_reg    <= pend & en_reg;
      rdata_reg    <= rdata_next;
    end
  end

  assign offer_o     = offer_reg;
  assign reg_rdata_o = rdata_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  offer_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i |=> offer_o == $past(pend & en_reg)) else $error("offer not gated by enable");
  evt_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && (evt_pulse != 64'h0000_0000_0000_0000)
    |=> (evt_pulse & $past(evt_pulse)) == 64'h0000_0000_0000_0000)
    else $error("event pulse longer than one cycle");
  shadow_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_rd_i && is_shadow |=> (reg_rdata_o & ~$past(acc_half)) == 32'h0000_0000)
    else $error("shadow read leaked a foreign channel");
  global_pend_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_rd_i && !is_shadow && word_ok && pair_off == OFF_PEND && !hi_half
    |=> reg_rdata_o == $past(pend[31:0])) else $error("global read mismatch");
  evt_latch_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && evt_pulse != 64'h0000_0000_0000_0000
    |=> (pend & $past(evt_pulse)) == $past(evt_pulse)) else $error("event not latched");
  svc_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && service_i && !evt_pulse[service_ch_i]
    |=> !pend[$past(service_ch_i)]) else $error("serviced channel still pending");
  miss_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr_missclr && (evt_pulse & pend) == 64'h0000_0000_0000_0000
    |=> (miss & $past(wbits)) == 64'h0000_0000_0000_0000) else $error("miss clear ignored");
  zero_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr_clr && !service_i
    |=> ($past(pend) & ~pend & ~$past(wbits)) == 64'h0000_0000_0000_0000)
    else $error("pending cleared without a one");
  freeze_regs_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ce_i |=> $stable(en_reg) && $stable(rae_reg) && $stable(offer_o) && $stable(reg_rdata_o))
    else $error("registers moved while frozen");

  // ------------------------------------------------------------
  // register bus checks
  // ------------------------------------------------------------
  pend_high_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_rd_i && !is_shadow && word_ok && pair_off == OFF_PEND && hi_half
    |=> reg_rdata_o == $past(pend[63:32])) else $error("high pending read mismatch");
  miss_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_rd_i && !is_shadow && word_ok && pair_off == OFF_MISS && !hi_half
    |=> reg_rdata_o == $past(miss[31:0])) else $error("low miss read mismatch");
  miss_high_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_rd_i && !is_shadow && word_ok && pair_off == OFF_MISS && hi_half
    |=> reg_rdata_o == $past(miss[63:32])) else $error("high miss read mismatch");
  clr_rd_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_rd_i && (pair_off == OFF_CLR || pair_off == OFF_MISSCLR)
    |=> reg_rdata_o == 32'h0000_0000) else $error("clear register read not zero");
  en_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_rd_i && !is_shadow && word_ok && pair_off == OFF_EN && !hi_half
    |=> reg_rdata_o == $past(en_reg[31:0])) else $error("enable read mismatch");
  odd_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_rd_i && !word_ok
    |=> reg_rdata_o == 32'h0000_0000) else $error("unaligned read not zero");
  rd_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && !reg_rd_i
    |=> $stable(reg_rdata_o)) else $error("read data moved without a read");
  en_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr_en && !is_shadow && !hi_half
    |=> en_reg[31:0] == $past(reg_wdata_i)) else $error("low enable write lost");
  en_wr_high_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr_en && !is_shadow && hi_half
    |=> en_reg[63:32] == $past(reg_wdata_i)) else $error("high enable write lost");
  // a shadow write may only move channels that its region owns
  en_shadow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr_en && is_shadow
    |=> ((en_reg ^ $past(en_reg)) & ~$past(rae_reg)) == 64'h0000_0000_0000_0000)
    else $error("shadow write reached a foreign channel");
  rae_global_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_wr_i && is_shadow
    |=> $stable(rae_reg)) else $error("access enables written from shadow range");
  rae_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr_rae && !hi_half
    |=> rae_reg[31:0] == $past(reg_wdata_i)) else $error("access enable write lost");

  shadow_wr_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr_clr && is_shadow);
  svc_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && service_i ##2 offer_o == 64'h0000_0000_0000_0000);
  miss_rd_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_rd_i && pair_off == OFF_MISS && rd_word != 32'h0000_0000);
endmodule
`default_nettype wire

// ### sim/evt_prio_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// prioritizer stand-in: services the lowest offered channel
// ------------------------------------------------------------
module evt_prio_model
  import evt_cap_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              en_i,
  input  wire logic [NUM_CH-1:0] offer_i,
  output logic                   service_o,
  output logic      [CH_W-1:0]   service_ch_o
);
  int gap;
  initial begin
    gap = 0;
    service_o = 1'b0;
    service_ch_o = '0;
  end
  always @(negedge clk_i) begin
    service_o <= 1'b0;
    // released bus toggles so a stale number is never mistaken for valid
    service_ch_o <= ~service_ch_o;
    if (gap > 0) begin
      gap <= gap - 1;
    end else if (en_i && offer_i != '0) begin
      for (int i = NUM_CH - 1; i >= 0; i--) begin
        if (offer_i[i]) service_ch_o <= i[CH_W-1:0];
      end
      service_o <= 1'b1;
      // offer lags pending, so hold off until the clear shows
      gap <= 3;
    end
  end
endmodule
`default_nettype wire

// ### sim/test_evt_capture.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module test_evt_capture;
  import evt_cap_pkg::*;
  logic              clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              ce_i = 1'b1;
  logic [NUM_CH-1:0] evt_i = '0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [NUM_CH-1:0] offer_o;
  logic              service_i;
  logic [CH_W-1:0]   service_ch_i;
  logic              svc_en = 1'b0;
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                cycles = 0;

  always #2 clk_i = ~clk_i;

  evt_capture i_dut (.evt_i(evt_i), .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .service_i(service_i), .service_ch_i(service_ch_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .offer_o(offer_o));
  evt_prio_model i_prio (.clk_i(clk_i), .en_i(svc_en), .offer_i(offer_o),
    .service_o(service_i), .service_ch_o(service_ch_i));

  // ------------------------------------------------------------
  // access tasks: one cycle of strobe and events, then one idle
  // ------------------------------------------------------------
  task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d,
                     input logic [63:0] ev);
    @(negedge clk_i);
    reg_wr_i = w;
    reg_addr_i = a;
    reg_wdata_i = d;
    evt_i = ev;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    evt_i = '0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    @(negedge clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    `CHK(reg_rdata_o, e)
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rd(9'h000, 32'h0000_0000);
    rd(9'h004, 32'h0000_0000);
    rd(9'h010, 32'h0000_0000);
    rd(9'h018, 32'h0000_0000);
    acc(1'b0, 9'h000, 32'h0, 64'h8);
    rd(9'h000, 32'h0000_0008);
    `CHK(offer_o, 64'h0)
    acc(1'b1, 9'h008, 32'h0, 64'h0);
    rd(9'h000, 32'h0000_0008);
    acc(1'b1, 9'h008, 32'h8, 64'h0);
    rd(9'h000, 32'h0000_0000);
    // set racing a clear on an idle bit
    acc(1'b1, 9'h008, 32'h8, 64'h8);
    rd(9'h000, 32'h0000_0008);
    rd(9'h018, 32'h0000_0000);
    // set racing a clear on a pending bit loses the event
    acc(1'b1, 9'h008, 32'h8, 64'h8);
    rd(9'h000, 32'h0000_0008);
    rd(9'h018, 32'h0000_0008);
    // enabled channel in the high half
    acc(1'b1, 9'h014, 32'h100, 64'h0);
    acc(1'b0, 9'h000, 32'h0, 64'h100_0000_0000);
    rd(9'h004, 32'h0000_0100);
    `CHK(offer_o, 64'h100_0000_0000)
    acc(1'b0, 9'h000, 32'h0, 64'h100_0000_0000);
    rd(9'h01C, 32'h0000_0100);
    svc_en <= 1'b1;
    repeat (6) @(negedge clk_i);
    rd(9'h004, 32'h0000_0000);
    rd(9'h000, 32'h0000_0008);
    `CHK(offer_o, 64'h0)
    svc_en <= 1'b0;
    // shadow range with no access enabled, then one channel opened
    rd(9'h100, 32'h0000_0000);
    acc(1'b1, 9'h028, 32'h8, 64'h0);
    rd(9'h100, 32'h0000_0008);
    acc(1'b1, 9'h110, 32'hFFFF_FFFF, 64'h0);
    rd(9'h010, 32'h0000_0008);
    `CHK(offer_o, 64'h8)
    svc_en <= 1'b1;
    repeat (6) @(negedge clk_i);
    rd(9'h000, 32'h0000_0000);
    svc_en <= 1'b0;
    // shadow clear reaches only the channel its region owns
    acc(1'b0, 9'h000, 32'h0, 64'h18);
    acc(1'b1, 9'h108, 32'hFFFF_FFFF, 64'h0);
    rd(9'h000, 32'h0000_0010);
    acc(1'b1, 9'h020, 32'h8, 64'h0);
    rd(9'h018, 32'h0000_0000);
    rd(9'h01C, 32'h0000_0100);
    rd(9'h008, 32'h0000_0000);
    // enable low: an event and a write seen only while frozen are dropped
    @(negedge clk_i);
    ce_i = 1'b0;
    acc(1'b1, 9'h028, 32'h20, 64'h20);
    ce_i = 1'b1;
    rd(9'h000, 32'h0000_0010);
    rd(9'h028, 32'h0000_0008);
    summarize();
  end
endmodule
`default_nettype wire
